// [verilog/ssp_ctrl.sv]
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`include "ssp_params.svh"
// What this block does
// - overwrite off: byte into full buffer sets overflow, old byte kept
// - overwrite on: every new byte stored, overflow still raised if buffer full
// - while I2C busy, writes setting sequence bits are ignored, never queued
// - while I2C busy, writes to the shift buffer are discarded
module ssp_ctrl
  import ssp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        spi_sck,
  input  wire logic        spi_sdi,
  input  wire logic        spi_ss_n,
  output logic             spi_sdo,
  output logic             spi_sdo_oe,
  input  wire logic        i2c_sda_i,
  output logic             i2c_sda_o,
  output logic             i2c_sda_oe,
  output logic             i2c_scl_o,
  output logic             i2c_scl_oe,
  output logic             irq
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pins_s;
  logic       ss_n_s, sck_s, sdi_s, sda_s;

  ssp_sync #(.WIDTH(4), .RST(4'h9)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({spi_ss_n, spi_sck, spi_sdi, i2c_sda_i}),
    .sync_out (pins_s)
  );
  assign {ss_n_s, sck_s, sdi_s, sda_s} = pins_s;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [1:0]  ctrl_q, ctrl_d;
  logic [7:0]  con2_q, con2_d;
  logic [7:0]  con3_q, con3_d;
  logic [7:0]  rx_q, rx_d;
  logic [7:0]  tx_q, tx_d;
  logic        bf_q, bf_d;
  logic        ovf_q, ovf_d;
  logic [2:0]  irq_st_q, irq_st_d;
  logic [2:0]  mask_q, mask_d;
  logic [7:0]  baud_q, baud_d;
  logic [7:0]  div_q, div_d;
  logic        tick_q, tick_d;
  logic        tx_pend_q, tx_pend_d;
  logic        go_q, go_d;
  ssp_op_t     op_q, op_d;
  logic        busy_q, busy_d;
  logic        sck_prev_q, sck_prev_d;
  logic [3:0]  scnt_q, scnt_d;
  logic [7:0]  ssh_q, ssh_d;
  logic        sdo_q, sdo_d;
  logic        sdo_oe_q, sdo_oe_d;
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic        irq_q, irq_d;

  logic        seq_busy, seq_done, seq_ack;
  logic [7:0]  seq_rx;
  logic        scl_low, sda_low;
  logic        spi_on, i2c_on;
  logic        acc, wr_acc, rd_acc;
  logic        rx_evt;
  logic [7:0]  rx_new;

  assign spi_on = ctrl_q[`SSP_CTRL_EN] & ~ctrl_q[`SSP_CTRL_I2C];
  assign i2c_on = ctrl_q[`SSP_CTRL_EN] & ctrl_q[`SSP_CTRL_I2C];
  assign acc    = psel & penable & pready_q;
  assign wr_acc = acc & pwrite;
  assign rd_acc = acc & ~pwrite;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction

  // ----------------------------------------------------------------
  // condition and byte engine
  // ----------------------------------------------------------------
  ssp_i2c_seq u_seq (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick_q),
    .go      (go_q),
    .op      (op_q),
    .tx_byte (tx_q),
    .ack_bit (con2_q[`SSP_C2_ACK_DATA_VALUE]),
    .sda_in  (sda_s),
    .busy    (seq_busy),
    .done    (seq_done),
    .rx_byte (seq_rx),
    .ack_in  (seq_ack),
    .scl_low (scl_low),
    .sda_low (sda_low)
  );

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_d     = ctrl_q;
    con2_d     = con2_q;
    con3_d     = con3_q;
    rx_d       = rx_q;
    tx_d       = tx_q;
    bf_d       = bf_q;
    ovf_d      = ovf_q;
    irq_st_d   = irq_st_q;
    mask_d     = mask_q;
    baud_d     = baud_q;
    tx_pend_d  = tx_pend_q;
    go_d       = 1'b0;
    op_d       = op_q;
    busy_d     = busy_q;
    sck_prev_d = sck_s;
    scnt_d     = scnt_q;
    ssh_d      = ssh_q;
    sdo_d      = sdo_q;
    sdo_oe_d   = spi_on & ~ss_n_s;
    rx_evt     = 1'b0;
    rx_new     = seq_rx;
    pready_d   = psel & penable & ~pready_q;
    pslverr_d  = 1'b0;
    prdata_d   = prdata_q;

    // baud divider gives one-cycle ticks for the bus engine
    tick_d = 1'b0;
    div_d  = div_q - 8'h01;
    if (div_q == 8'h00) begin
      div_d  = baud_q;
      tick_d = 1'b1;
    end

    // spi slave, mode 0; sck only trusted while select is low
    if (!spi_on || ss_n_s) begin
      scnt_d = 4'h0;
      ssh_d  = tx_q;
      sdo_d  = tx_q[7];
    end else if (sck_s && !sck_prev_q) begin
      ssh_d  = {ssh_q[6:0], sdi_s};
      scnt_d = scnt_q + 4'h1;
      if (scnt_q == `SSP_SPI_BITS - 4'h1) begin
        rx_evt = 1'b1;
        rx_new = {ssh_q[6:0], sdi_s};
        scnt_d = 4'h0;
      end
    end else if (!sck_s && sck_prev_q) begin
      sdo_d = ssh_q[7];
      if (scnt_q == 4'h0) begin
        ssh_d = tx_q;
        sdo_d = tx_q[7];
      end
    end

    // register access; hardware events below win over these clears
    if (pready_d) begin
      if (hit(paddr, `SSP_OFF_CTRL)) begin
        prdata_d = {30'h0, ctrl_q};
      end else if (hit(paddr, `SSP_OFF_CON2)) begin
        prdata_d = {24'h0, con2_q};
      end else if (hit(paddr, `SSP_OFF_CON3)) begin
        prdata_d = {24'h0, con3_q};
      end else if (hit(paddr, `SSP_OFF_BUF)) begin
        prdata_d = {24'h0, rx_q};
      end else if (hit(paddr, `SSP_OFF_STATUS)) begin
        prdata_d = {29'h0, busy_q, ovf_q, bf_q};
      end else if (hit(paddr, `SSP_OFF_IRQ_ST)) begin
        prdata_d = {29'h0, irq_st_q};
      end else if (hit(paddr, `SSP_OFF_IRQ_MASK)) begin
        prdata_d = {29'h0, mask_q};
      end else if (hit(paddr, `SSP_OFF_BAUD)) begin
        prdata_d = {24'h0, baud_q};
      end else begin
        prdata_d  = 32'h0000_0000;
        pslverr_d = 1'b1;
      end
    end
    if (rd_acc && hit(paddr, `SSP_OFF_BUF)) begin
      bf_d = 1'b0;
    end
    if (rd_acc && hit(paddr, `SSP_OFF_IRQ_ST)) begin
      irq_st_d = `SSP_IRQ_RST;
    end
    if (wr_acc) begin
      if (hit(paddr, `SSP_OFF_CTRL)) begin
        ctrl_d = pwdata[1:0];
      end else if (hit(paddr, `SSP_OFF_CON2)) begin
        con2_d[`SSP_C2_GENERAL_CALL_ENABLE]  = pwdata[`SSP_C2_GENERAL_CALL_ENABLE];
        con2_d[`SSP_C2_ACK_DATA_VALUE] = pwdata[`SSP_C2_ACK_DATA_VALUE];
        if (!busy_q) begin
          con2_d[4:0] = pwdata[4:0];
        end
      end else if (hit(paddr, `SSP_OFF_CON3)) begin
        con3_d = pwdata[7:0];
      end else if (hit(paddr, `SSP_OFF_BUF)) begin
        if (!busy_q) begin
          tx_d      = pwdata[7:0];
          tx_pend_d = i2c_on;
        end
      end else if (hit(paddr, `SSP_OFF_STATUS)) begin
        if (pwdata[`SSP_ST_OVF]) begin
          ovf_d = 1'b0;
        end
      end else if (hit(paddr, `SSP_OFF_IRQ_MASK)) begin
        mask_d = pwdata[2:0];
      end else if (hit(paddr, `SSP_OFF_BAUD)) begin
        baud_d = pwdata[7:0];
      end
    end

    // launch one operation at a time; start has the highest priority
    if (i2c_on && !busy_q) begin
      busy_d = 1'b1;
      go_d   = 1'b1;
      if (con2_q[`SSP_C2_SEN]) begin
        op_d = SSP_OP_START;
      end else if (con2_q[`SSP_C2_REPEATED_START_ENABLE]) begin
        op_d = SSP_OP_RSTART;
      end else if (con2_q[`SSP_C2_PEN]) begin
        op_d = SSP_OP_STOP;
      end else if (con2_q[`SSP_C2_MASTER_RECEIVE_ENABLE]) begin
        op_d = SSP_OP_RECV;
      end else if (con2_q[`SSP_C2_ACK_SEQUENCE_ENABLE]) begin
        op_d = SSP_OP_ACK;
      end else if (tx_pend_q) begin
        op_d      = SSP_OP_WRITE;
        tx_pend_d = 1'b0;
      end else begin
        busy_d = 1'b0;
        go_d   = 1'b0;
      end
    end

    // completion clears the matching enable bit
    if (seq_done) begin
      busy_d      = 1'b0;
      irq_st_d[`SSP_IRQ_DONE] = 1'b1;
      case (op_q)
        SSP_OP_START:  con2_d[`SSP_C2_SEN]   = 1'b0;
        SSP_OP_RSTART: con2_d[`SSP_C2_REPEATED_START_ENABLE]  = 1'b0;
        SSP_OP_STOP:   con2_d[`SSP_C2_PEN]   = 1'b0;
        SSP_OP_ACK:    con2_d[`SSP_C2_ACK_SEQUENCE_ENABLE] = 1'b0;
        SSP_OP_RECV: begin
          con2_d[`SSP_C2_MASTER_RECEIVE_ENABLE] = 1'b0;
          rx_evt = 1'b1;
        end
        SSP_OP_WRITE:  con2_d[`SSP_C2_ACK_RECEIVED_STATUS] = seq_ack;
        default:       con2_d = con2_d;
      endcase
    end
    if (!i2c_on && !seq_busy) begin
      busy_d = 1'b0;
    end

    // received byte into the buffer
    if (rx_evt) begin
      irq_st_d[`SSP_IRQ_RX] = 1'b1;
      if (bf_q) begin
        ovf_d = 1'b1;
        irq_st_d[`SSP_IRQ_OVF] = 1'b1;
        if (con3_q[`SSP_C3_BUFFER_OVERWRITE_ENABLE]) begin
          rx_d = rx_new;
        end
      end else begin
        rx_d = rx_new;
      end
      bf_d = 1'b1;
    end

    irq_d = |(irq_st_d & mask_q);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q     <= `SSP_CTRL_RST;
      con2_q     <= `SSP_BYTE_RST;
      con3_q     <= `SSP_BYTE_RST;
      rx_q       <= `SSP_BYTE_RST;
      tx_q       <= `SSP_BYTE_RST;
      bf_q       <= 1'b0;
      ovf_q      <= 1'b0;
      irq_st_q   <= `SSP_IRQ_RST;
      mask_q     <= `SSP_IRQ_RST;
      baud_q     <= `SSP_BAUD_RST;
      div_q      <= `SSP_BAUD_RST;
      tick_q     <= 1'b0;
      tx_pend_q  <= 1'b0;
      go_q       <= 1'b0;
      op_q       <= SSP_OP_NONE;
      busy_q     <= 1'b0;
      sck_prev_q <= 1'b0;
      scnt_q     <= 4'h0;
      ssh_q      <= `SSP_BYTE_RST;
      sdo_q      <= 1'b0;
      sdo_oe_q   <= 1'b0;
      pready_q   <= 1'b0;
      pslverr_q  <= 1'b0;
      prdata_q   <= 32'h0000_0000;
      irq_q      <= 1'b0;
    end else begin
      ctrl_q     <= ctrl_d;
      con2_q     <= con2_d;
      con3_q     <= con3_d;
      rx_q       <= rx_d;
      tx_q       <= tx_d;
      bf_q       <= bf_d;
      ovf_q      <= ovf_d;
      irq_st_q   <= irq_st_d;
      mask_q     <= mask_d;
      baud_q     <= baud_d;
      div_q      <= div_d;
      tick_q     <= tick_d;
      tx_pend_q  <= tx_pend_d;
      go_q       <= go_d;
      op_q       <= op_d;
      busy_q     <= busy_d;
      sck_prev_q <= sck_prev_d;
      scnt_q     <= scnt_d;
      ssh_q      <= ssh_d;
      sdo_q      <= sdo_d;
      sdo_oe_q   <= sdo_oe_d;
      pready_q   <= pready_d;
      pslverr_q  <= pslverr_d;
      prdata_q   <= prdata_d;
      irq_q      <= irq_d;
    end
  end

  // open-drain lines only ever pull low
  assign i2c_sda_o  = 1'b0;
  assign i2c_scl_o  = 1'b0;
  assign i2c_sda_oe = sda_low;
  assign i2c_scl_oe = scl_low;
  assign spi_sdo    = sdo_q;
  assign spi_sdo_oe = sdo_oe_q;
  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign irq        = irq_q;
endmodule

// [verilog/ssp_params.svh]
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define SSP_OFF_CTRL     8'h00
`define SSP_OFF_CON2     8'h04
`define SSP_OFF_CON3     8'h08
`define SSP_OFF_BUF      8'h0c
`define SSP_OFF_STATUS   8'h10
`define SSP_OFF_IRQ_ST   8'h14
`define SSP_OFF_IRQ_MASK 8'h18
`define SSP_OFF_BAUD     8'h1c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SSP_CTRL_EN      0
`define SSP_CTRL_I2C     1
`define SSP_C2_SEN       0
`define SSP_C2_REPEATED_START_ENABLE      1
`define SSP_C2_PEN       2
`define SSP_C2_MASTER_RECEIVE_ENABLE      3
`define SSP_C2_ACK_SEQUENCE_ENABLE     4
`define SSP_C2_ACK_DATA_VALUE     5
`define SSP_C2_ACK_RECEIVED_STATUS   6
`define SSP_C2_GENERAL_CALL_ENABLE      7
`define SSP_C3_BUFFER_OVERWRITE_ENABLE      4
`define SSP_ST_BF        0
`define SSP_ST_OVF       1
`define SSP_ST_ACTIVE    2
`define SSP_IRQ_RX       0
`define SSP_IRQ_OVF      1
`define SSP_IRQ_DONE     2

// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define SSP_CTRL_RST     2'h0
`define SSP_BYTE_RST     8'h00
`define SSP_IRQ_RST      3'h0
`define SSP_BAUD_RST     8'h04
`define SSP_SPI_BITS     4'h8
`define SSP_I2C_WR_BITS  4'h9
`define SSP_I2C_RD_BITS  4'h8
`define SSP_I2C_ONE_BIT  4'h1

`endif

// [verilog/ssp_pkg.sv]
package ssp_pkg;

  typedef enum logic [6:0] {
    SSP_OP_START  = 7'b0000001,
    SSP_OP_RSTART = 7'b0000010,
    SSP_OP_STOP   = 7'b0000100,
    SSP_OP_RECV   = 7'b0001000,
    SSP_OP_ACK    = 7'b0010000,
    SSP_OP_WRITE  = 7'b0100000,
    SSP_OP_NONE   = 7'b1000000
  } ssp_op_t;

  typedef enum logic [1:0] {
    SSP_ST_IDLE = 2'b01,
    SSP_ST_RUN  = 2'b10
  } ssp_state_t;

endpackage

// [verilog/ssp_sync.sv]
`timescale 1ns/10ps
module ssp_sync #(
  parameter int         WIDTH = 1,
  parameter logic [3:0] RST   = 4'h0
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= RST[WIDTH-1:0];
      sync_q <= RST[WIDTH-1:0];
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule

// [verilog/ssp_i2c_seq.sv]
`timescale 1ns/10ps
`include "ssp_params.svh"
module ssp_i2c_seq
  import ssp_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       tick,
  input  wire logic       go,
  input  ssp_op_t         op,
  input  wire logic [7:0] tx_byte,
  input  wire logic       ack_bit,
  input  wire logic       sda_in,
  output logic            busy,
  output logic            done,
  output logic      [7:0] rx_byte,
  output logic            ack_in,
  output logic            scl_low,
  output logic            sda_low
);
  ssp_state_t state_q, state_d;
  ssp_op_t    op_q, op_d;
  logic [1:0] phase_q, phase_d;
  logic [3:0] bit_q, bit_d;
  logic [3:0] nbits;
  logic [7:0] sh_q, sh_d;
  logic       ack_q, ack_d;
  logic       done_q, done_d;
  logic       scl_q, scl_d;
  logic       sda_q, sda_d;
  logic       dlow;

  always_comb begin
    state_d = state_q;
    op_d    = op_q;
    phase_d = phase_q;
    bit_d   = bit_q;
    sh_d    = sh_q;
    ack_d   = ack_q;
    done_d  = 1'b0;
    scl_d   = scl_q;
    sda_d   = sda_q;
    nbits   = `SSP_I2C_ONE_BIT;
    if (op_q == SSP_OP_WRITE) begin
      nbits = `SSP_I2C_WR_BITS;
    end else if (op_q == SSP_OP_RECV) begin
      nbits = `SSP_I2C_RD_BITS;
    end
    // ack bit sits in sh_q[7]; released for receive and the write ack slot
    dlow = ~sh_q[7];
    if (op_q == SSP_OP_RECV || (op_q == SSP_OP_WRITE && bit_q == 4'h8)) begin
      dlow = 1'b0;
    end
    case (state_q)
      SSP_ST_IDLE: begin
        if (go) begin
          state_d = SSP_ST_RUN;
          op_d    = op;
          phase_d = 2'd0;
          bit_d   = 4'h0;
          sh_d    = (op == SSP_OP_ACK) ? {ack_bit, 7'h00} : tx_byte;
        end
      end
      SSP_ST_RUN: begin
        if (tick) begin
          case (op_q)
            SSP_OP_START: begin
              scl_d = (phase_q == 2'd3);
              sda_d = (phase_q != 2'd0);
            end
            SSP_OP_RSTART: begin
              scl_d = (phase_q == 2'd0) || (phase_q == 2'd3);
              sda_d = (phase_q >= 2'd2);
            end
            SSP_OP_STOP: begin
              scl_d = (phase_q == 2'd0);
              sda_d = (phase_q != 2'd3);
            end
            default: begin
              scl_d = (phase_q == 2'd0) || (phase_q == 2'd3);
              sda_d = dlow;
            end
          endcase
          if (phase_q == 2'd2) begin
            if (op_q == SSP_OP_RECV) begin
              sh_d = {sh_q[6:0], sda_in};
            end else if (op_q == SSP_OP_WRITE && bit_q == 4'h8) begin
              ack_d = sda_in;
            end
          end
          if (phase_q == 2'd3 && op_q == SSP_OP_WRITE) begin
            sh_d = {sh_q[6:0], 1'b0};
          end
          phase_d = phase_q + 2'd1;
          if (phase_q == 2'd3) begin
            if (bit_q == nbits - 4'h1) begin
              state_d = SSP_ST_IDLE;
              done_d  = 1'b1;
            end else begin
              bit_d = bit_q + 4'h1;
            end
          end
        end
      end
      default: begin
        state_d = SSP_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= SSP_ST_IDLE;
      op_q    <= SSP_OP_NONE;
      phase_q <= 2'd0;
      bit_q   <= 4'h0;
      sh_q    <= `SSP_BYTE_RST;
      ack_q   <= 1'b0;
      done_q  <= 1'b0;
      scl_q   <= 1'b0;
      sda_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      op_q    <= op_d;
      phase_q <= phase_d;
      bit_q   <= bit_d;
      sh_q    <= sh_d;
      ack_q   <= ack_d;
      done_q  <= done_d;
      scl_q   <= scl_d;
      sda_q   <= sda_d;
    end
  end

  assign busy    = (state_q == SSP_ST_RUN);
  assign done    = done_q;
  assign rx_byte = sh_q;
  assign ack_in  = ack_q;
  assign scl_low = scl_q;
  assign sda_low = sda_q;
endmodule

// [verif/ssp_ctrl_monitor.sv]
`timescale 1ns/10ps
module ssp_ctrl_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic spi_ss_n,
  input wire logic spi_sdo_oe,
  input wire logic i2c_sda_o,
  input wire logic i2c_scl_o,
  input wire logic i2c_sda_oe,
  input wire logic i2c_scl_oe
);
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held over one cycle");
  chk_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("access phase not one wait state");
  chk_open_drain: assert property (i2c_sda_o == 1'b0 && i2c_scl_o == 1'b0)
    else $error("open drain data driven high");
  // sync stages plus register: four cycles of ss_n high are enough
  chk_sdo_off: assert property (spi_ss_n [*4] |-> !spi_sdo_oe)
    else $error("sdo enabled while deselected");
  chk_start_shape: assert property ($rose(i2c_sda_oe) && !i2c_scl_oe |-> ##[1:1000] i2c_scl_oe)
    else $error("start condition never pulls clock");
endmodule

bind ssp_ctrl ssp_ctrl_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .spi_ss_n(spi_ss_n), .spi_sdo_oe(spi_sdo_oe), .i2c_sda_o(i2c_sda_o),
  .i2c_scl_o(i2c_scl_o), .i2c_sda_oe(i2c_sda_oe), .i2c_scl_oe(i2c_scl_oe));

// [verif/ssp_far_end.sv]
`timescale 1ns/10ps
module ssp_far_end (
  input wire logic       i2c_sda_oe,
  input wire logic       i2c_scl_oe,
  input wire logic       rd_mode,
  input wire logic [7:0] rd_byte,
  input wire logic       spi_sdo,
  output logic           sda,
  output logic           scl,
  output logic           spi_sck,
  output logic           spi_sdi,
  output logic           spi_ss_n,
  output logic     [7:0] got_byte,
  output logic     [7:0] spi_got,
  output logic           got_ack
);
  // ----------------------------------------------------------------
  // i2c slave, lines pulled up, no stretching
  // ----------------------------------------------------------------
  logic [3:0] cnt;
  logic       pull;
  initial begin
    cnt = 4'h0;
    got_byte = 8'h00;
    spi_got = 8'h00;
    got_ack = 1'b1;
    spi_sck = 1'b0;
    spi_sdi = 1'b0;
    spi_ss_n = 1'b1;
  end
  assign pull = rd_mode ? (cnt < 4'h8 && !rd_byte[3'h7 - cnt[2:0]]) : (cnt == 4'h8);
  assign sda = !(i2c_sda_oe || pull);
  assign scl = !i2c_scl_oe;
  // first clock fall after a start begins bit zero
  always @(negedge sda) if (scl) cnt <= 4'h8;
  always @(negedge scl) cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
  always @(posedge scl) begin
    if (cnt < 4'h8) got_byte <= {got_byte[6:0], sda};
    else got_ack <= sda;
  end
  // ----------------------------------------------------------------
  // spi master, mode 0, clock only inside frames
  // ----------------------------------------------------------------
  task automatic spi_xfer(input logic [7:0] b);
    #3 spi_ss_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      spi_sdi = b[i];
      #32 spi_sck = 1'b1;
      // mode 0: slave output is sampled on the rising clock
      spi_got = {spi_got[6:0], spi_sdo};
      #32 spi_sck = 1'b0;
    end
    #32 spi_ss_n = 1'b1;
    // released line must not keep the last bit
    spi_sdi = !spi_sdi;
  endtask
endmodule

// [verif/testbench.sv]
`timescale 1ns/10ps
`include "ssp_params.svh"
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, rd_mode, err, pready, pslverr, irq, got_ack;
  logic        sck, sdi, ss_n, sdo, sdo_oe, sda, scl, sda_o, sda_oe, scl_o, scl_oe;
  logic [7:0]  paddr, rd_byte, got_byte, b1, b2, spi_got;
  logic [31:0] pwdata, prdata, r;
  int          n_mismatch, checked, seed;

  initial pclk = 1'b0;
  always #4 pclk = ~pclk;

  ssp_ctrl i_ssp_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .spi_sck(sck),
    .spi_sdi(sdi), .spi_ss_n(ss_n), .spi_sdo(sdo), .spi_sdo_oe(sdo_oe), .i2c_sda_i(sda), .i2c_sda_o(sda_o),
    .i2c_sda_oe(sda_oe), .i2c_scl_o(scl_o), .i2c_scl_oe(scl_oe), .irq(irq));
  ssp_far_end i_ssp_far_end (.i2c_sda_oe(sda_oe), .i2c_scl_oe(scl_oe), .rd_mode(rd_mode), .rd_byte(rd_byte),
    .spi_sdo(sdo), .sda(sda), .scl(scl), .spi_sck(sck), .spi_sdi(sdi), .spi_ss_n(ss_n), .got_byte(got_byte),
    .spi_got(spi_got), .got_ack(got_ack));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task wrap_up;
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) n_mismatch++;
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(r, exp);
  endtask
  task wait_idle;
    int k;
    k = 0;
    do begin
      apb(1'b0, `SSP_OFF_STATUS, 32'h0);
      k++;
    end while (r[`SSP_ST_ACTIVE] !== 1'b0 && k < 300);
    if (k >= 300) n_mismatch++;
  endtask
  task spi(input logic [7:0] b);
    i_ssp_far_end.spi_xfer(b);
    repeat (8) @(posedge pclk);
  endtask
  function automatic logic [31:0] ack_word(input int i);
    return (i == 0) ? 32'h30 : 32'h10;
  endfunction

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    #400000;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    seed = 32'h3fe4;
    {presetn, psel, penable, pwrite, rd_mode} = 5'h00;
    {paddr, rd_byte, pwdata} = 48'h0;
    n_mismatch = 0;
    checked = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`SSP_OFF_CTRL, 32'h0);
    rd(`SSP_OFF_CON2, 32'h0);
    rd(`SSP_OFF_CON3, 32'h0);
    rd(`SSP_OFF_STATUS, 32'h0);
    rd(`SSP_OFF_BAUD, 32'h4);
    apb(1'b0, 8'h20, 32'h0);
    check({31'h0, err}, 32'h1);
    check(r, 32'h0);
    apb(1'b1, `SSP_OFF_IRQ_MASK, 32'h7);
    apb(1'b1, `SSP_OFF_CTRL, 32'h1);
    b1 = 8'($random(seed));
    b2 = 8'($random(seed));
    apb(1'b1, `SSP_OFF_BUF, {24'h0, b2});
    spi(b1);
    check({31'h0, irq}, 32'h1);
    check({24'h0, spi_got}, {24'h0, b2});
    spi(b2);
    rd(`SSP_OFF_STATUS, 32'h3);
    rd(`SSP_OFF_BUF, {24'h0, b1});
    rd(`SSP_OFF_IRQ_ST, 32'h3);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, `SSP_OFF_STATUS, 32'h2);
    apb(1'b1, `SSP_OFF_CON3, 32'h10);
    spi(8'hff);
    spi(8'h00);
    rd(`SSP_OFF_STATUS, 32'h3);
    rd(`SSP_OFF_BUF, 32'h0);
    // i2c: a stop asked during the start must not run later
    apb(1'b1, `SSP_OFF_BAUD, 32'h1);
    apb(1'b1, `SSP_OFF_CTRL, 32'h3);
    apb(1'b1, `SSP_OFF_CON2, 32'h1);
    apb(1'b1, `SSP_OFF_CON2, 32'h4);
    wait_idle();
    rd(`SSP_OFF_CON2, 32'h0);
    check({31'h0, sda_oe}, 32'h1);
    rd(`SSP_OFF_IRQ_ST, 32'h7);
    apb(1'b1, `SSP_OFF_BUF, {24'h0, b1});
    apb(1'b1, `SSP_OFF_BUF, {24'h0, ~b1});
    wait_idle();
    check({24'h0, got_byte}, {24'h0, b1});
    rd(`SSP_OFF_CON2, 32'h0);
    for (int i = 0; i < 2; i++) begin
      rd_byte <= 8'($random(seed));
      rd_mode <= 1'b1;
      apb(1'b1, `SSP_OFF_CON2, 32'h8);
      wait_idle();
      rd(`SSP_OFF_BUF, {24'h0, rd_byte});
      // slave stays in read mode, else it would pull the master's ack slot
      apb(1'b1, `SSP_OFF_CON2, ack_word(i));
      wait_idle();
      check({31'h0, got_ack}, (ack_word(i) >> 5) & 32'h1);
      rd(`SSP_OFF_CON2, ack_word(i) & 32'h20);
    end
    rd_mode <= 1'b0;
    apb(1'b1, `SSP_OFF_CON2, 32'h4);
    wait_idle();
    check({31'h0, sda}, 32'h1);
    rd(`SSP_OFF_CON2, 32'h0);
    wrap_up();
  end
endmodule
